// *** hw/dcf_status.sv ***
// status, flags and fill levels of a dual-clock first-in first-out buffer
// assumes write and read clocks arrive as pins sampled by the 100 MHz clock
//
// What this block does
// [R1] thresholds fixed or from ports, chosen at build
// [R2] programmable flags rise a cycle after threshold
// [R3] programmable flags fall after crossing negate threshold
// [R4] read shows on full after 1+3+N
// [R5] write shows on empty after 1+3+N
// [R6] synchroniser stage count is parameter N
// [R8] fill count per side, in own domain
// [R9] fill counts are approximations only
// [R10] fill counts may jump by several
// [R11] counts exact after a few idle cycles
// [R12] crossing safe for any clock relation
// [R13] full sets on filling write edge
// [R14] empty sets on emptying read edge
// [R15] crossing pointers gray coded, one bit
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dcf_status #(
	parameter int                    AW      = `DCF_ADDR_W_DEF,
	parameter int                    NSYNC   = `DCF_NSYNC_DEF,
	parameter dcf_pkg::dcf_thr_src_t THR_SRC = dcf_pkg::DCF_THR_PORT,
	parameter int                    SETTLE  = `DCF_SETTLE_DEF
) (
	// system clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// producer side pins
	input  wire logic                wr_clk_pin,
	input  wire logic                wr_en,
	// consumer side pins
	input  wire logic                rd_clk_pin,
	input  wire logic                rd_en,
	// storage core hookup
	output logic                     wr_fire,
	output logic                     rd_fire,
	output logic      [AW-1:0]       wr_addr,
	output logic      [AW-1:0]       rd_addr,
	// flags and fill levels
	output logic                     full,
	output logic                     empty,
	output logic                     prog_full,
	output logic                     prog_empty,
	output logic      [AW:0]         wr_level,
	output logic      [AW:0]         rd_level,
	// register port
	input  wire dcf_pkg::dcf_addr_t  reg_addr,
	input  wire dcf_pkg::dcf_word_t  reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output dcf_pkg::dcf_word_t       reg_rdata
);
	import dcf_pkg::*;

	localparam int CW = AW + 1;

	// ----------------------------------------------------------------
	// build checks
	// ----------------------------------------------------------------
	generate
		if (AW < 2 || AW > 30 || NSYNC < 2 || SETTLE < 1) begin : g_bad
			$error("dcf_status: unsupported AW, NSYNC or SETTLE");
		end
	endgenerate

	function automatic logic [CW-1:0] bin2gray(input logic [CW-1:0] b);
		return b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [CW-1:0] gray2bin(input logic [CW-1:0] g);
		logic [CW-1:0] b;
		b = g;
		for (int i = CW - 2; i >= 0; i--) begin
			b[i] = g[i] ^ b[i+1];
		end
		return b;
	endfunction : gray2bin

	// ----------------------------------------------------------------
	// pin sampling and edge finding
	// ----------------------------------------------------------------
	// enables ride the same two stages as their clocks so they stay aligned
	logic [3:0] pin1_q;
	logic [3:0] pin2_q;
	logic       wclk3_q;
	logic       rclk3_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			pin1_q  <= 4'h0;
			pin2_q  <= 4'h0;
			wclk3_q <= 1'b0;
			rclk3_q <= 1'b0;
		end else begin
			pin1_q  <= {rd_en, rd_clk_pin, wr_en, wr_clk_pin};
			pin2_q  <= pin1_q;
			wclk3_q <= pin2_q[0];
			rclk3_q <= pin2_q[2];
		end
	end

	wire wr_tick = pin2_q[0] & ~wclk3_q;
	wire rd_tick = pin2_q[2] & ~rclk3_q;

	// ----------------------------------------------------------------
	// pointers
	// ----------------------------------------------------------------
	logic [CW-1:0] wbin_q;
	logic [CW-1:0] wgray_q;
	logic [CW-1:0] rbin_q;
	logic [CW-1:0] rgray_q;
	logic [CW-1:0] rgray_at_w;
	logic [CW-1:0] wgray_at_r;
	logic          full_q;
	logic          empty_q;

	// writes into a full buffer and reads of an empty one are dropped
	assign wr_fire = wr_tick & pin2_q[1] & ~full_q;
	assign rd_fire = rd_tick & pin2_q[3] & ~empty_q;

	wire [CW-1:0] wbin_d  = wbin_q + CW'(wr_fire);
	wire [CW-1:0] rbin_d  = rbin_q + CW'(rd_fire);
	wire [CW-1:0] wgray_d = bin2gray(wbin_d);
	wire [CW-1:0] rgray_d = bin2gray(rbin_d);

	// full compares against the read pointer with the top two bits turned
	wire [CW-1:0] rgray_flip = {~rgray_at_w[CW-1:CW-2], rgray_at_w[CW-3:0]};
	wire          full_d     = (wgray_d == rgray_flip);
	wire          empty_d    = (rgray_d == wgray_at_r);

	// [R13] [R14] flags set on the edge
	always_ff @(posedge clock) begin
		if (rst) begin
			wbin_q  <= '0;
			wgray_q <= '0;
			full_q  <= 1'b0;
		end else if (wr_tick) begin
			wbin_q  <= wbin_d;
			wgray_q <= wgray_d;
			full_q  <= full_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rbin_q  <= '0;
			rgray_q <= '0;
			empty_q <= 1'b1;
		end else if (rd_tick) begin
			rbin_q  <= rbin_d;
			rgray_q <= rgray_d;
			empty_q <= empty_d;
		end
	end

	// ----------------------------------------------------------------
	// crossings
	// ----------------------------------------------------------------
	// [R6] [R12] N-stage gray crossing
	dcf_ptr_sync #(.W(CW), .STAGES(NSYNC)) u_r2w (
		.clock (clock),
		.rst   (rst),
		.en    (wr_tick),
		.d     (rgray_q),
		.q     (rgray_at_w)
	);

	dcf_ptr_sync #(.W(CW), .STAGES(NSYNC)) u_w2r (
		.clock (clock),
		.rst   (rst),
		.en    (rd_tick),
		.d     (wgray_q),
		.q     (wgray_at_r)
	);

	// ----------------------------------------------------------------
	// fill levels and programmable flags
	// ----------------------------------------------------------------
	// [R8] [R9] [R10] per-side levels from delayed far pointers
	wire [CW-1:0] wr_level_d = wbin_q - gray2bin(rgray_at_w);
	wire [CW-1:0] rd_level_d = gray2bin(wgray_at_r) - rbin_q;

	logic [CW-1:0] wr_level_q;
	logic [CW-1:0] rd_level_q;
	logic          pfull_q;
	logic          pempty_q;
	logic [CW-1:0] pf_set_q;
	logic [CW-1:0] pf_clr_q;
	logic [CW-1:0] pe_set_q;
	logic [CW-1:0] pe_clr_q;

	// [R1] threshold source fixed at build time
	wire          thr_port = (THR_SRC == DCF_THR_PORT);
	wire [CW-1:0] pf_set   = thr_port ? pf_set_q : CW'(`DCF_PF_SET_RST);
	wire [CW-1:0] pf_clr   = thr_port ? pf_clr_q : CW'(`DCF_PF_CLR_RST);
	wire [CW-1:0] pe_set   = thr_port ? pe_set_q : CW'(`DCF_PE_SET_RST);
	wire [CW-1:0] pe_clr   = thr_port ? pe_clr_q : CW'(`DCF_PE_CLR_RST);

	// [R2] [R3] flags follow the registered level, one edge late
	wire pfull_d  = pfull_q ? (wr_level_q >= pf_clr) : (wr_level_q >= pf_set);
	wire pempty_d = pempty_q ? (rd_level_q <= pe_clr) : (rd_level_q <= pe_set);

	always_ff @(posedge clock) begin
		if (rst) begin
			wr_level_q <= '0;
			pfull_q    <= 1'b0;
		end else if (wr_tick) begin
			wr_level_q <= wr_level_d;
			pfull_q    <= pfull_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rd_level_q <= '0;
			pempty_q   <= 1'b1;
		end else if (rd_tick) begin
			rd_level_q <= rd_level_d;
			pempty_q   <= pempty_d;
		end
	end

	assign full       = full_q;
	assign empty      = empty_q;
	assign prog_full  = pfull_q;
	assign prog_empty = pempty_q;
	assign wr_level   = wr_level_q;
	assign rd_level   = rd_level_q;
	assign wr_addr    = wbin_q[AW-1:0];
	assign rd_addr    = rbin_q[AW-1:0];

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	wire hit_pf_set = (reg_addr == `DCF_OFS_PF_SET);
	wire hit_pf_clr = (reg_addr == `DCF_OFS_PF_CLR);
	wire hit_pe_set = (reg_addr == `DCF_OFS_PE_SET);
	wire hit_pe_clr = (reg_addr == `DCF_OFS_PE_CLR);

	always_ff @(posedge clock) begin
		if (rst) begin
			pf_set_q <= CW'(`DCF_PF_SET_RST);
			pf_clr_q <= CW'(`DCF_PF_CLR_RST);
			pe_set_q <= CW'(`DCF_PE_SET_RST);
			pe_clr_q <= CW'(`DCF_PE_CLR_RST);
		end else if (reg_wr) begin
			if (hit_pf_set) pf_set_q <= reg_wdata[CW-1:0];
			if (hit_pf_clr) pf_clr_q <= reg_wdata[CW-1:0];
			if (hit_pe_set) pe_set_q <= reg_wdata[CW-1:0];
			if (hit_pe_clr) pe_clr_q <= reg_wdata[CW-1:0];
		end
	end

	dcf_word_t status_w;
	dcf_word_t rd_mux;
	always_comb begin
		status_w = '0;
		status_w[`DCF_ST_FULL]   = full_q;
		status_w[`DCF_ST_EMPTY]  = empty_q;
		status_w[`DCF_ST_PFULL]  = pfull_q;
		status_w[`DCF_ST_PEMPTY] = pempty_q;
		unique case (reg_addr)
			`DCF_OFS_PF_SET:   rd_mux = 32'(pf_set);
			`DCF_OFS_PF_CLR:   rd_mux = 32'(pf_clr);
			`DCF_OFS_PE_SET:   rd_mux = 32'(pe_set);
			`DCF_OFS_PE_CLR:   rd_mux = 32'(pe_clr);
			`DCF_OFS_STATUS:   rd_mux = status_w;
			`DCF_OFS_WR_LEVEL: rd_mux = 32'(wr_level_q);
			`DCF_OFS_RD_LEVEL: rd_mux = 32'(rd_level_q);
			default:           rd_mux = '0;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : '0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// idle cycles since the last accepted transfer
	logic [15:0] idle_q;
	always_ff @(posedge clock) begin
		if (rst || wr_fire || rd_fire) begin
			idle_q <= '0;
		end else if (idle_q != 16'hffff) begin
			idle_q <= idle_q + 16'h0001;
		end
	end

	property p_wgray_step;
		##1 $countones(wgray_q ^ $past(wgray_q)) <= 1;
	endproperty
	a_wgray_step: assert property (p_wgray_step) // [R15]
		else $error("write gray pointer moved by more than one bit");

	property p_rgray_step;
		##1 $countones(rgray_q ^ $past(rgray_q)) <= 1;
	endproperty
	a_rgray_step: assert property (p_rgray_step) // [R15]
		else $error("read gray pointer moved by more than one bit");

	property p_full_now;
		wr_fire && ((wbin_q - gray2bin(rgray_at_w)) == CW'((1 << AW) - 1)) |=> full_q;
	endproperty
	a_full_now: assert property (p_full_now) // [R13]
		else $error("full not set on the filling write");

	property p_empty_now;
		rd_fire && ((gray2bin(wgray_at_r) - rbin_q) == CW'(1)) |=> empty_q;
	endproperty
	a_empty_now: assert property (p_empty_now) // [R14]
		else $error("empty not set on the emptying read");

	property p_pf_late;
		$rose(pfull_q) |-> $past(wr_level_q >= pf_set);
	endproperty
	a_pf_late: assert property (p_pf_late) // [R2]
		else $error("prog_full rose before level met threshold");

	property p_pe_late;
		$rose(pempty_q) |-> $past(rd_level_q <= pe_set);
	endproperty
	a_pe_late: assert property (p_pe_late) // [R2]
		else $error("prog_empty rose before level met threshold");

	property p_pf_drop;
		$fell(pfull_q) |-> $past(wr_level_q < pf_clr);
	endproperty
	a_pf_drop: assert property (p_pf_drop) // [R3]
		else $error("prog_full fell above negate threshold");

	property p_pe_drop;
		$fell(pempty_q) |-> $past(rd_level_q > pe_clr);
	endproperty
	a_pe_drop: assert property (p_pe_drop) // [R3]
		else $error("prog_empty fell below negate threshold");

	property p_full_clears;
		rd_fire && full_q |-> ##[1:400] !full_q;
	endproperty
	a_full_clears: assert property (p_full_clears) // [R4]
		else $error("full did not clear after a read");

	property p_empty_clears;
		wr_fire && empty_q |-> ##[1:400] !empty_q;
	endproperty
	a_empty_clears: assert property (p_empty_clears) // [R5]
		else $error("empty did not clear after a write");

	property p_settle;
		idle_q >= 16'(SETTLE) |-> wr_level_q == rd_level_q;
	endproperty
	a_settle: assert property (p_settle) // [R11]
		else $error("fill levels disagree after idle period");
endmodule : dcf_status

// *** hw/dcf_defs.svh ***
// register offsets, status bit positions and reset values for the
// dual-clock buffer status block; included by the block and its bench
`ifndef DCF_DEFS_SVH
`define DCF_DEFS_SVH

// register byte offsets on the plain register port
`define DCF_OFS_PF_SET   8'h00
`define DCF_OFS_PF_CLR   8'h04
`define DCF_OFS_PE_SET   8'h08
`define DCF_OFS_PE_CLR   8'h0c
`define DCF_OFS_STATUS   8'h10
`define DCF_OFS_WR_LEVEL 8'h14
`define DCF_OFS_RD_LEVEL 8'h18

// status register bit positions
`define DCF_ST_FULL   0
`define DCF_ST_EMPTY  1
`define DCF_ST_PFULL  2
`define DCF_ST_PEMPTY 3

// threshold reset values (also the fixed constants when not programmable)
`define DCF_PF_SET_RST 32'h0000000c
`define DCF_PF_CLR_RST 32'h0000000a
`define DCF_PE_SET_RST 32'h00000004
`define DCF_PE_CLR_RST 32'h00000006

// defaults of the build parameters
`define DCF_ADDR_W_DEF 4
`define DCF_NSYNC_DEF  2
`define DCF_SETTLE_DEF 600

`endif

// *** hw/dcf_pkg.sv ***
// types shared by the dual-clock buffer status block
// assumes nothing beyond a SystemVerilog compiler
package dcf_pkg;
	typedef logic [31:0] dcf_word_t;
	typedef logic [7:0]  dcf_addr_t;
	// where the occupancy thresholds come from, fixed at build time
	typedef enum logic [1:0] {
		DCF_THR_CONST = 2'b01,
		DCF_THR_PORT  = 2'b10
	} dcf_thr_src_t;
endpackage : dcf_pkg

// *** hw/dcf_ptr_sync.sv ***
// multi-stage synchroniser for a gray-coded pointer
// assumes the source changes at most one bit per update
`timescale 1ns/100ps
module dcf_ptr_sync #(
	parameter int W      = 5,
	parameter int STAGES = 2
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// stage advance, one pulse per emulated destination clock edge
	input  wire logic         en,
	// pointer in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [STAGES-1:0][W-1:0] stage_q;

	generate
		if (STAGES < 2) begin : g_bad
			$error("dcf_ptr_sync needs at least two stages");
		end
	endgenerate

	// first stage feeds only the second one
	always_ff @(posedge clock) begin
		if (rst) begin
			stage_q <= '0;
		end else if (en) begin
			stage_q <= {stage_q[STAGES-2:0], d};
		end
	end

	assign q = stage_q[STAGES-1];
endmodule : dcf_ptr_sync

// *** tb/dcf_link_model.sv ***
// producer and consumer pins of the dual-clock buffer status block
// assumes the bench raises wr_want and rd_want to ask for traffic
`timescale 1ns/100ps
module dcf_link_model #(
	parameter realtime HALF  = 62.5,
	parameter realtime PHASE = 17.3
) (
	// requests from the bench
	input  wire logic wr_want,
	input  wire logic rd_want,
	// pins towards the block
	output logic      wr_clk_pin,
	output logic      wr_en,
	output logic      rd_clk_pin,
	output logic      rd_en
);
	// --------------------------------
	// free-running pin clocks
	// --------------------------------
	// equal 125 ns periods, depth 16
	initial begin
		wr_clk_pin = 1'b0;
		forever #(HALF) wr_clk_pin = ~wr_clk_pin;
	end
	// phase unrelated to the system clock
	initial begin
		rd_clk_pin = 1'b0;
		#(PHASE);
		forever #(HALF) rd_clk_pin = ~rd_clk_pin;
	end
	// --------------------------------
	// enables move away from rising pin edges
	// --------------------------------
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	always @(negedge wr_clk_pin) wr_en <= wr_want;
	always @(negedge rd_clk_pin) rd_en <= rd_want;
endmodule : dcf_link_model

// *** tb/dcf_status_bench.sv ***
// self-checking bench for the dual-clock buffer status block
// assumes a 100 MHz system clock and 125 ns pin clocks from the model
`timescale 1ns/100ps
`include "dcf_defs.svh"
module dcf_status_bench;
	import dcf_pkg::*;
	localparam int DEPTH = 16;
	localparam int NS    = 2;
	localparam int LIMIT = 40000;
	logic               clock, rst, wr_want, rd_want, reg_wr, reg_rd;
	logic               wr_clk_pin, wr_en, rd_clk_pin, rd_en, wr_fire, rd_fire;
	logic               full, empty, prog_full, prog_empty, prog_full_c;
	logic [3:0]         wr_addr, rd_addr;
	logic [4:0]         wr_level, rd_level;
	dcf_addr_t          reg_addr;
	dcf_word_t          reg_wdata, reg_rdata, rdata_c, rv, rv_c;
	int                 errors = 0, tests_run = 0, cycles = 0;
	int                 wr_cnt = 0, rd_cnt = 0, lat, moved;

	// settle window cut to what 125 ns pin periods need
	dcf_status #(.AW(4), .NSYNC(NS), .SETTLE(200)) dut_u (.clock(clock), .rst(rst),
		.wr_clk_pin(wr_clk_pin), .wr_en(wr_en), .rd_clk_pin(rd_clk_pin), .rd_en(rd_en),
		.wr_fire(wr_fire), .rd_fire(rd_fire), .wr_addr(wr_addr), .rd_addr(rd_addr),
		.full(full), .empty(empty), .prog_full(prog_full), .prog_empty(prog_empty),
		.wr_level(wr_level), .rd_level(rd_level), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// second copy with fixed thresholds, sharing every input
	dcf_status #(.AW(4), .NSYNC(NS), .THR_SRC(DCF_THR_CONST), .SETTLE(200)) dut_c (
		.clock(clock), .rst(rst),
		.wr_clk_pin(wr_clk_pin), .wr_en(wr_en), .rd_clk_pin(rd_clk_pin), .rd_en(rd_en),
		.wr_fire(), .rd_fire(), .wr_addr(), .rd_addr(), .full(), .empty(),
		.prog_full(prog_full_c), .prog_empty(), .wr_level(), .rd_level(),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(rdata_c));
	dcf_link_model link_u (.wr_want(wr_want), .rd_want(rd_want), .wr_clk_pin(wr_clk_pin),
		.wr_en(wr_en), .rd_clk_pin(rd_clk_pin), .rd_en(rd_en));

	// --------------------------------
	// clock, watchdog, transfer counters
	// --------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// running totals only; tasks take differences
	always @(posedge clock) begin
		cycles++;
		wr_cnt += int'(wr_fire === 1'b1);
		rd_cnt += int'(rd_fire === 1'b1);
	end

	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic reg_write(input dcf_addr_t a, input dcf_word_t d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr    <= 1'b0;
		// one idle edge so a following strobe is never assigned twice at once
		@(posedge clock);
	endtask : reg_write
	task automatic reg_read(input dcf_addr_t a);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		// read data stand only up to this edge
		@(posedge clock);
		rv   = reg_rdata;
		rv_c = rdata_c;
	endtask : reg_read
	// move words until the count is met or a flag rises; for DEPTH or more words keep asking 100 edges so refused requests occur
	task automatic run_until(input bit wr, input int words);
		int w0;
		int r0;
		w0 = wr_cnt;
		r0 = rd_cnt;
		if (wr) wr_want <= 1'b1;
		else rd_want <= 1'b1;
		while ((wr ? wr_cnt - w0 : rd_cnt - r0) < words && !(wr ? full : empty))
			@(posedge clock);
		if (words >= DEPTH) repeat (100) @(posedge clock);
		wr_want <= 1'b0;
		rd_want <= 1'b0;
		repeat (200) @(posedge clock);
		moved = wr ? wr_cnt - w0 : rd_cnt - r0;
	endtask : run_until

	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_reset_regs();
		check("full", full, 1'b0);
		check("empty", empty, 1'b1);
		check("prog_full", prog_full, 1'b0);
		check("prog_empty", prog_empty, 1'b1);
		reg_read(`DCF_OFS_PF_SET);
		check("pf_set", rv, `DCF_PF_SET_RST);
		reg_read(`DCF_OFS_PF_CLR);
		check("pf_clr", rv, `DCF_PF_CLR_RST);
		reg_read(`DCF_OFS_PE_SET);
		check("pe_set", rv, `DCF_PE_SET_RST);
		reg_read(`DCF_OFS_PE_CLR);
		check("pe_clr", rv, `DCF_PE_CLR_RST);
		reg_write(8'h1c, 32'h0000001f);
		reg_read(8'h1c);
		check("unmapped", rv, 32'h0);
		reg_read(`DCF_OFS_STATUS);
		check("status", rv, 32'h0000000a);
		$display("test reset_regs done");
	endtask : t_reset_regs
	task automatic t_fill_drain();
		run_until(1'b1, DEPTH);
		check("writes", moved, DEPTH);
		check("full", full, 1'b1);
		check("wr_level", wr_level, 5'h10);
		check("rd_level", rd_level, 5'h10);
		reg_read(`DCF_OFS_STATUS);
		check("status", rv, 32'h00000005);
		run_until(1'b0, DEPTH);
		check("reads", moved, DEPTH);
		check("wr_level", wr_level, 5'h00);
		reg_read(`DCF_OFS_RD_LEVEL);
		check("rd_level", rv, 32'h0);
		reg_read(`DCF_OFS_STATUS);
		check("status", rv, 32'h0000000a);
		$display("test fill_drain done");
	endtask : t_fill_drain
	task automatic t_empty_latency();
		wr_want <= 1'b1;
		while (wr_fire !== 1'b1) @(posedge clock);
		wr_want <= 1'b0;
		lat = 0;
		while (empty === 1'b1 && lat < 400) begin
			@(posedge clock);
			lat++;
		end
		// one write period, then 3+N read periods, plus pin sampling
		check("empty_lat_ok", lat > 0 && lat <= (1 + 3 + NS) * 13 + 6, 1'b1);
		// seventeenth write since reset lands at slot zero and leaves wr_addr at one
		check("wr_addr", wr_addr, 4'h1);
		run_until(1'b0, DEPTH);
		check("reads", moved, 1);
		check("rd_addr", rd_addr, 4'h1);
		check("empty", empty, 1'b1);
		$display("test empty_latency done");
	endtask : t_empty_latency
	task automatic t_thresholds();
		reg_write(`DCF_OFS_PF_SET, 32'hffffffe5);
		reg_write(`DCF_OFS_PF_CLR, 32'h00000004);
		reg_read(`DCF_OFS_PF_SET);
		check("pf_set", rv, 32'h00000005);
		check("pf_set_const", rv_c, `DCF_PF_SET_RST);
		run_until(1'b1, 5);
		check("wr_level", wr_level, 5'h05);
		check("prog_full", prog_full, 1'b1);
		check("prog_full_const", prog_full_c, 1'b0);
		check("full", full, 1'b0);
		run_until(1'b0, DEPTH);
		check("prog_full", prog_full, 1'b0);
		check("prog_empty", prog_empty, 1'b1);
		$display("test thresholds done");
	endtask : t_thresholds

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	initial begin
		rst = 1'b1;
		wr_want = 1'b0;
		rd_want = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		fork
			begin
				t_reset_regs();
				t_fill_drain();
				t_empty_latency();
				t_thresholds();
			end
			begin
				// a hang counts as a mismatch and still reaches the verdict
				wait (cycles >= LIMIT);
				check("timeout", 32'h1, 32'h0);
			end
		join_any
		disable fork;
		report_and_stop();
	end
endmodule : dcf_status_bench
